// File: rtl/vfr_pkg.sv
/*
  Shared constants and carrier types for the video field reducer.
  Assumes one clock at the pixel rate and AXI4-Lite register access.
*/
package vfr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PIX_W = 8;
  localparam int unsigned RED_W = 10;
  localparam int unsigned SUM_W = 11;
  localparam int unsigned IMG_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PORT_W = 16;
  localparam int unsigned PH_W = 2;
  localparam int unsigned FS_DEPTH = 49152;
  localparam int unsigned IS_DEPTH = 49152;
  localparam int unsigned TI_IMAGE = 49152;
  localparam int unsigned ROI_COLS = 128;
  localparam int unsigned ROI_ROWS = 384;
  localparam int unsigned DIV_BY = 6;
  localparam logic [PH_W-1:0] PROC_LAST = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FADDR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FDATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IDATA = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TDATA = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PORT = 8'h1C;
  localparam int unsigned CTRL_CAPTURE = 0;
  localparam int unsigned CTRL_FS_INC = 1;
  localparam int unsigned CTRL_IM_INC = 2;
  localparam int unsigned CTRL_PORT_DRV = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic hblank;
    logic vblank;
    logic [PIX_W-1:0] data;
  } vfr_video_t;
  typedef struct packed {
    logic [PH_W-1:0] phase;
    logic np_own;
    logic np_req;
    logic vblank;
    logic hblank;
  } vfr_cond_t;
endpackage

// File: rtl/vfr_sync.sv
/*
  Two flip-flop synchroniser for a vector of independent levels.
  Assumes each bit changes slowly relative to the clock.
*/
`timescale 1ns/1ps
module vfr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] hold_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      hold_ff <= '0;
    end else begin
      meta_ff <= din;
      hold_ff <= meta_ff;
    end
  end

  assign dout = hold_ff;
endmodule // vfr_sync

// File: rtl/vfr_div6.sv
/*
  Divide-by-six table: each two-field sum maps to the low eight bits of a sixth of itself.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps
module vfr_div6
  import vfr_pkg::*;
(
  input wire logic [vfr_pkg::SUM_W-1:0] sum,
  output logic [vfr_pkg::IMG_W-1:0] quot
);
  logic [SUM_W-1:0] full;

  always_comb begin
    full = sum / SUM_W'(DIV_BY);
    quot = full[IMG_W-1:0];
  end
endmodule // vfr_div6

// File: rtl/vfr_top.sv
/*
  Video field reducer: blanking and data alignment, 3:1 reduction,
  two-field average through a field store, image store and port.
  Assumes async video, blanking and handshake pins; AXI4-Lite master.
  // Function
  // - Sampling logic runs at pixel rate
  // - Other logic runs at one third rate
  // - Detect line start phase, pass on
  // - Three delay taps, phase selects tap
  // - Blanking levels visible as conditions
  // - Sum three aligned pixels into ten bits
  // - Field counter loadable, increments when enabled
  // - Field store captures central region only
  // - Software reads and writes field store
  // - Add live and previous field pixel
  // - Divide two-field sum by six
  // - Image counter loadable, readable, addresses both
  // - Increment local writing, remote reading
  // - Remote side selects increment owner
  // - Remote may only increment image counter
  // - Image store keeps averaged central region
  // - Read-only test table at image counter
  // - One 16-bit bidirectional port, no select
  // - Handshake inputs visible as conditions
  // - Handshake inputs pass synchronisers
  // - No shift count, no double addressing
  // - Square region, one third as wide
  // - One source drives internal bus
*/
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module vfr_top #(
  parameter int unsigned COL_START = 32,
  parameter int unsigned ROW_START = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [vfr_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [vfr_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire vfr_pkg::vfr_video_t vid_in,
  input wire logic np_req,
  input wire logic np_own,
  input wire logic [vfr_pkg::PORT_W-1:0] np_data_i,
  output logic [vfr_pkg::PORT_W-1:0] np_data_o,
  output logic np_data_oe_n,
  output logic np_ack
);
  import vfr_pkg::*;

  localparam int unsigned SYNC_W = $bits(vfr_video_t) + 2 + PORT_W;

  logic [SYNC_W-1:0] sync_out;
  vfr_video_t vid_s;
  logic np_req_s, np_own_s;
  logic [PORT_W-1:0] np_in_s;
  logic [PH_W-1:0] ph_ff, line_phase_ff;
  logic proc_tick, hb_d_ff, line_start, np_req_d_ff, np_inc;
  logic [PIX_W-1:0] dly_ff [3];
  logic [PIX_W-1:0] aligned;
  logic [RED_W-1:0] acc_ff, red_ff;
  logic red_vld_ff;
  logic [CNT_W-1:0] col_ff, row_ff, faddr_ff, iac_ff;
  logic [3:0] ctrl_ff;
  logic [PORT_W-1:0] port_out_ff;
  logic [RED_W-1:0] fs_mem [FS_DEPTH];
  logic [IMG_W-1:0] is_mem [IS_DEPTH];
  logic in_roi, store, aw_got_ff, w_got_ff, wr_fire;
  logic [RED_W-1:0] prev_pix;
  logic [SUM_W-1:0] two_sum;
  logic [IMG_W-1:0] avg_pix;
  logic [ADDR_W-1:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  vfr_cond_t cond;

  function automatic logic [RED_W-1:0] fs_rd(input logic [CNT_W-1:0] a);
    fs_rd = (32'(a) < FS_DEPTH) ? fs_mem[a] : '0;
  endfunction

  function automatic logic [IMG_W-1:0] is_rd(input logic [CNT_W-1:0] a);
    is_rd = (32'(a) < IS_DEPTH) ? is_mem[a] : '0;
  endfunction

  // Arbitrary stand-in pattern for the stored test image
  function automatic logic [IMG_W-1:0] test_rd(input logic [CNT_W-1:0] a);
    test_rd = (32'(a) < TI_IMAGE) ? (a[15:8] ^ a[7:0]) : '0;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_FADDR) || (a == OFS_FDATA) ||
             (a == OFS_IADDR) || (a == OFS_IDATA) || (a == OFS_TDATA) ||
             (a == OFS_STATUS) || (a == OFS_PORT);
  endfunction

  // Pin inputs through two flops
  vfr_sync #(.W(SYNC_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({vid_in, np_req, np_own, np_data_i}),
    .dout(sync_out)
  );
  assign {vid_s, np_req_s, np_own_s, np_in_s} = sync_out;

  // Processor-rate enable, every third pixel clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_ff <= '0;
    end else begin
      ph_ff <= (ph_ff == PROC_LAST) ? '0 : ph_ff + 2'h1;
    end
  end
  assign proc_tick = (ph_ff == PROC_LAST);

  // End of horizontal blanking and its phase
  assign line_start = hb_d_ff && !vid_s.hblank;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hb_d_ff <= 1'b0;
      line_phase_ff <= '0;
    end else begin
      hb_d_ff <= vid_s.hblank;
      if (line_start) begin
        line_phase_ff <= ph_ff;
      end
    end
  end

  // Delay chain, phase picks tap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_ff <= '{default: '0};
    end else begin
      dly_ff[0] <= vid_s.data;
      dly_ff[1] <= dly_ff[0];
      dly_ff[2] <= dly_ff[1];
    end
  end
  assign aligned = dly_ff[line_phase_ff];

  // Three-pixel horizontal sum
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= '0;
      red_ff <= '0;
      red_vld_ff <= 1'b0;
    end else if (proc_tick) begin
      red_ff <= acc_ff + RED_W'(aligned);
      acc_ff <= '0;
      red_vld_ff <= 1'b1;
    end else begin
      acc_ff <= acc_ff + RED_W'(aligned);
      red_vld_ff <= 1'b0;
    end
  end

  // Column and line position within the field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      col_ff <= '0;
      row_ff <= '0;
    end else begin
      if (line_start) begin
        col_ff <= '0;
      end else if (red_vld_ff && !vid_s.hblank) begin
        col_ff <= col_ff + 16'h0001;
      end
      if (vid_s.vblank) begin
        row_ff <= '0;
      end else if (line_start) begin
        row_ff <= row_ff + 16'h0001;
      end
    end
  end
  assign in_roi = (32'(col_ff) >= COL_START) && (32'(col_ff) < COL_START + ROI_COLS) &&
                  (32'(row_ff) > ROW_START) && (32'(row_ff) <= ROW_START + ROI_ROWS);

  assign store = red_vld_ff && ctrl_ff[CTRL_CAPTURE] && in_roi &&
                 !vid_s.hblank && !vid_s.vblank;
  assign prev_pix = fs_rd(faddr_ff);
  assign two_sum = SUM_W'(red_ff) + SUM_W'(prev_pix);

  vfr_div6 u_div6 (
    .sum(two_sum),
    .quot(avg_pix)
  );

  // Remote increment on each rising request
  assign np_inc = np_req_s && !np_req_d_ff;

  // Bus write decode
  assign wr_fire = aw_got_ff && w_got_ff && !s_bvalid;

  // Stores: video path wins over software in the same cycle
  always_ff @(posedge aclk) begin
    if (store) begin
      if (32'(faddr_ff) < FS_DEPTH) begin
        fs_mem[faddr_ff] <= red_ff;
      end
      if (32'(iac_ff) < IS_DEPTH) begin
        is_mem[iac_ff] <= avg_pix;
      end
    end else if (wr_fire && wstrb_ff[0]) begin
      if (waddr_ff == OFS_FDATA && 32'(faddr_ff) < FS_DEPTH) begin
        fs_mem[faddr_ff] <= wdata_ff[RED_W-1:0];
      end
      if (waddr_ff == OFS_IDATA && 32'(iac_ff) < IS_DEPTH) begin
        is_mem[iac_ff] <= wdata_ff[IMG_W-1:0];
      end
    end
  end

  // Field address counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      faddr_ff <= '0;
    end else if (wr_fire && waddr_ff == OFS_FADDR && wstrb_ff[1:0] == 2'h3) begin
      faddr_ff <= wdata_ff[CNT_W-1:0];
    end else if (ctrl_ff[CTRL_FS_INC] && (store || (wr_fire && waddr_ff == OFS_FDATA))) begin
      faddr_ff <= faddr_ff + 16'h0001;
    end
  end

  // Image address counter: local load, owner-selected increment
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iac_ff <= '0;
    end else if (wr_fire && waddr_ff == OFS_IADDR && wstrb_ff[1:0] == 2'h3) begin
      iac_ff <= wdata_ff[CNT_W-1:0];
    end else if (np_own_s) begin
      if (np_inc) begin
        iac_ff <= iac_ff + 16'h0001;
      end
    end else if (ctrl_ff[CTRL_IM_INC] && (store || (wr_fire && waddr_ff == OFS_IDATA))) begin
      iac_ff <= iac_ff + 16'h0001;
    end
  end

  // Control and port output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RESET;
      port_out_ff <= '0;
    end else if (wr_fire) begin
      if (waddr_ff == OFS_CTRL && wstrb_ff[0]) begin
        ctrl_ff <= wdata_ff[3:0];
      end
      if (waddr_ff == OFS_PORT) begin
        if (wstrb_ff[0]) port_out_ff[7:0] <= wdata_ff[7:0];
        if (wstrb_ff[1]) port_out_ff[15:8] <= wdata_ff[15:8];
      end
    end
  end

  // Single port: image byte while remote owns, else software word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      np_req_d_ff <= 1'b0;
      np_ack <= 1'b0;
      np_data_o <= '0;
      np_data_oe_n <= 1'b1;
    end else begin
      np_req_d_ff <= np_req_s;
      np_ack <= np_req_s;
      np_data_o <= np_own_s ? PORT_W'(is_rd(iac_ff)) : port_out_ff;
      np_data_oe_n <= !(np_own_s || ctrl_ff[CTRL_PORT_DRV]);
    end
  end

  // Condition inputs for microcode branching
  assign cond = '{phase: line_phase_ff, np_own: np_own_s, np_req: np_req_s,
                  vblank: vid_s.vblank, hblank: vid_s.hblank};

  // Write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      waddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got_ff <= 1'b1;
        waddr_ff <= s_awaddr;
        s_awready <= 1'b0;
      end else if (!aw_got_ff && !s_bvalid) begin
        s_awready <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
        s_wready <= 1'b0;
      end else if (!w_got_ff && !s_bvalid) begin
        s_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= mapped(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one source selected per address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_araddr)
        OFS_CTRL: s_rdata <= 32'(ctrl_ff);
        OFS_FADDR: s_rdata <= 32'(faddr_ff);
        OFS_FDATA: s_rdata <= 32'(fs_rd(faddr_ff));
        OFS_IADDR: s_rdata <= 32'(iac_ff);
        OFS_IDATA: s_rdata <= 32'(is_rd(iac_ff));
        OFS_TDATA: s_rdata <= 32'(test_rd(iac_ff));
        OFS_STATUS: s_rdata <= 32'(cond);
        OFS_PORT: s_rdata <= 32'(np_in_s);
        default: s_rdata <= '0;
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end else if (!s_rvalid) begin
      s_arready <= 1'b1;
    end
  end

  // Checks
  AST_TICK_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
    proc_tick |=> !proc_tick ##1 !proc_tick ##1 proc_tick)
    else $error("processor enable not every third cycle");
  AST_PHASE_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
    line_start |=> line_phase_ff == $past(ph_ff))
    else $error("line phase not captured at blanking end");
  AST_RED_SUM: assert property (@(posedge aclk) disable iff (!aresetn)
    proc_tick |=> red_vld_ff && red_ff == $past(acc_ff) + RED_W'($past(aligned)))
    else $error("reduced sum wrong");
  AST_FADDR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_ff[CTRL_FS_INC] && !wr_fire |=> $stable(faddr_ff))
    else $error("field counter moved without enable");
  AST_FS_OVERWRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    store |=> fs_rd($past(faddr_ff)) == $past(red_ff))
    else $error("field store not written with live pixel");
  AST_DIV_SIX: assert property (@(posedge aclk) disable iff (!aresetn)
    store |=> is_rd($past(iac_ff)) == IMG_W'(32'($past(two_sum)) / DIV_BY))
    else $error("image store value not a sixth of two-field sum");
  AST_NP_INC: assert property (@(posedge aclk) disable iff (!aresetn)
    np_own_s && np_inc && !wr_fire |=> iac_ff == $past(iac_ff) + 16'h0001)
    else $error("remote increment lost");
  AST_NP_OWNS: assert property (@(posedge aclk) disable iff (!aresetn)
    np_own_s && !np_inc && !wr_fire |=> $stable(iac_ff))
    else $error("local increment while remote owns counter");
  AST_PORT_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    np_own_s |=> !np_data_oe_n ##0 np_data_o == PORT_W'(is_rd($past(iac_ff))))
    else $error("port not driving image byte for remote owner");
  AST_ACK_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(np_req_s) |=> np_ack ##1 (np_ack || !$past(np_req_s)))
    else $error("handshake acknowledge late");
  AST_BRESP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
endmodule // vfr_top

// File: test/vfr_np_model.sv
/*
  Numeric processor model: takes or yields the image counter increment
  and steps it by a four-phase request and acknowledge.
  Assumes the device samples the request and ownership asynchronously.
*/
`timescale 1ns/1ps
module vfr_np_model #(
  parameter logic [15:0] DRV_WORD = 16'hA5C3
) (
  input wire logic aclk,
  input wire logic np_ack,
  output logic np_req,
  output logic np_own,
  output logic [15:0] np_drv
);
  // Word offered whenever the device leaves the port
  assign np_drv = DRV_WORD;

  initial begin
    np_req = 1'b0;
    np_own = 1'b0;
  end

  // Owner command
  task automatic set_own(input logic v);
    np_own <= v;
  endtask

  // Increments only, never a load
  task automatic incr(input int n, input int gap);
    int t;
    for (int i = 0; i < n; i++) begin
      t = 0;
      np_req <= 1'b1;
      while (np_ack !== 1'b1 && t < 50) begin
        @(posedge aclk);
        t++;
      end
      repeat (gap) @(posedge aclk);
      np_req <= 1'b0;
      while (np_ack !== 1'b0 && t < 100) begin
        @(posedge aclk);
        t++;
      end
      @(posedge aclk);
    end
  endtask
endmodule // vfr_np_model

// File: test/test_video_field_reducer.sv
/*
  Bench for the video field reducer: register bus, stores, test table,
  remote increment and port. Assumes the numeric processor model beside it.
*/
`timescale 1ns/1ps
module test_video_field_reducer;
  import vfr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_awaddr = '0;
  logic [ADDR_W-1:0] s_araddr = '0;
  logic [31:0] s_wdata = '0;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic np_req, np_own, np_data_oe_n, np_ack;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [31:0] s_rdata, rd;
  logic [PORT_W-1:0] np_data_o, np_drv, np_wire;
  vfr_video_t vid_in = '0;
  logic hb = 1'b1;
  logic vb = 1'b1;
  logic vrand = 1'b1;
  logic [9:0] q;
  int n;
  logic [15:0] vseed = 16'h0057;
  logic [15:0] seed = 16'h0057;
  logic [15:0] a;
  logic [7:0] b0, b1;
  int err_count = 0;
  int checks_done = 0;

  always #10 aclk = ~aclk;
  assign np_wire = np_data_oe_n ? np_drv : np_data_o;

  vfr_top #(.COL_START(0), .ROW_START(0)) u_vfr_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .vid_in(vid_in), .np_req(np_req), .np_own(np_own), .np_data_i(np_wire),
    .np_data_o(np_data_o), .np_data_oe_n(np_data_oe_n), .np_ack(np_ack)
  );

  vfr_np_model u_vfr_np_model (
    .aclk(aclk), .np_ack(np_ack), .np_req(np_req), .np_own(np_own), .np_drv(np_drv)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] tbl_exp(input logic [15:0] x);
    return (32'(x) < TI_IMAGE) ? (x[15:8] ^ x[7:0]) : 8'h00;
  endfunction

  // Flat pixel summed three times, plus old field value, over six
  function automatic logic [7:0] avg_exp(input logic [7:0] p, input logic [9:0] f);
    return 8'((3 * int'(p) + int'(f)) / DIV_BY);
  endfunction

  // Random video with bench-held blanking
  always @(posedge aclk) begin
    vseed <= lfsr_next(vseed);
    vid_in <= {hb, vb, vrand ? vseed[7:0] : b0};
  end

  task automatic complete_run;
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t resp got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [ADDR_W-1:0] ad, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw, w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    s_awaddr <= ad;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while ((aw || w) && n < 100) begin
      @(posedge aclk);
      n++;
      if (aw && s_awready === 1'b1) begin
        aw = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w && s_wready === 1'b1) begin
        w = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    while (s_bvalid !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    r = s_bresp;
    s_bready <= 1'b0;
    if (n >= 100) err_count++;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] ad, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    s_araddr <= ad;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (s_arready !== 1'b1 && n < 100);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    if (n >= 100) err_count++;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [31:0] d);
    axi_wr(ad, d, rsp);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] ad, input logic [31:0] exp,
                        input logic [31:0] msk = 32'hFFFF_FFFF);
    axi_rd(ad, rd, rsp);
    chk_word(rd & msk, exp);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    complete_run;
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_wr(8'h20, 32'h0000_0001, rsp);
    chk_resp(rsp, RESP_SLVERR);
    axi_rd(8'h20, rd, rsp);
    chk_resp(rsp, RESP_SLVERR);
    chk_word(rd, 32'h0000_0000);
    // Field store through the bus
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      a = seed & 16'h7FFF;
      wr(OFS_FADDR, 32'(a));
      wr(OFS_FDATA, 32'(seed[15:6]));
      rd_chk(OFS_FADDR, 32'(a));
      rd_chk(OFS_FDATA, 32'(seed[15:6]));
    end
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_FADDR, 32'h0000_BFFE);
    wr(OFS_FDATA, 32'h0000_03FF);
    rd_chk(OFS_FADDR, 32'h0000_BFFF);
    wr(OFS_CTRL, 32'h0000_0000);
    // Test table, with both sides of the image boundary
    for (int i = 0; i < 5; i++) begin
      seed = lfsr_next(seed);
      a = (i == 3) ? 16'hBFFF : (i == 4) ? 16'hC000 : seed;
      wr(OFS_IADDR, 32'(a));
      rd_chk(OFS_IADDR, 32'(a));
      rd_chk(OFS_TDATA, 32'(tbl_exp(a)));
    end
    // Image store with local increments
    seed = lfsr_next(seed);
    a = seed & 16'h7FFF;
    b0 = seed[7:0];
    b1 = ~seed[15:8];
    wr(OFS_CTRL, 32'h0000_0004);
    wr(OFS_IADDR, 32'(a));
    wr(OFS_IDATA, 32'(b0));
    wr(OFS_IDATA, 32'(b1));
    rd_chk(OFS_IADDR, 32'(a + 16'h0002));
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_IADDR, 32'(a));
    rd_chk(OFS_IDATA, 32'(b0));
    // Remote owner steps the counter
    u_vfr_np_model.set_own(1'b1);
    repeat (4) @(posedge aclk);
    u_vfr_np_model.incr(1, 0);
    repeat (3) @(posedge aclk);
    chk_word(32'(np_data_o), 32'(b1));
    chk_word(32'(np_data_oe_n), 32'h0000_0000);
    u_vfr_np_model.incr(1, 5);
    rd_chk(OFS_IADDR, 32'(a + 16'h0002));
    rd_chk(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
    u_vfr_np_model.set_own(1'b0);
    repeat (4) @(posedge aclk);
    u_vfr_np_model.incr(2, 0);
    rd_chk(OFS_IADDR, 32'(a + 16'h0002));
    chk_word(32'(np_data_oe_n), 32'h0000_0001);
    // Port driven locally, then read back from the far side
    wr(OFS_CTRL, 32'h0000_0008);
    wr(OFS_PORT, 32'h0000_1234);
    repeat (2) @(posedge aclk);
    chk_word(32'(np_data_o), 32'h0000_1234);
    wr(OFS_CTRL, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    rd_chk(OFS_PORT, 32'h0000_A5C3);
    // Blanking levels as conditions
    hb <= 1'b1;
    vb <= 1'b0;
    repeat (6) @(posedge aclk);
    rd_chk(OFS_STATUS, 32'h0000_0001, 32'h0000_0003);
    hb <= 1'b0;
    vb <= 1'b1;
    repeat (6) @(posedge aclk);
    rd_chk(OFS_STATUS, 32'h0000_0002, 32'h0000_0003);
    // Capture part of one line of flat video
    seed = lfsr_next(seed);
    b0 = seed[7:0];
    q = seed[15:6];
    a = seed & 16'h3FFF;
    vrand <= 1'b0;
    hb <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_FADDR, 32'(a));
    for (int k = 0; k < 8; k++) wr(OFS_FDATA, 32'(q));
    wr(OFS_FADDR, 32'(a));
    wr(OFS_IADDR, 32'h0000_0100);
    wr(OFS_CTRL, 32'h0000_0007);
    hb <= 1'b0;
    vb <= 1'b0;
    repeat (12) @(posedge aclk);
    hb <= 1'b1;
    vb <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(OFS_CTRL, 32'h0000_0000);
    axi_rd(OFS_FADDR, rd, rsp);
    n = int'(rd) - int'(a);
    chk_word(32'(n > 0 && n < 8), 32'h0000_0001);
    rd_chk(OFS_IADDR, 32'h0000_0100 + 32'(n));
    for (int k = 0; k < 8; k++) begin
      wr(OFS_FADDR, 32'(a) + 32'(k));
      wr(OFS_IADDR, 32'h0000_0100 + 32'(k));
      rd_chk(OFS_FDATA, (k < n) ? 32'(3 * b0) : 32'(q));
      if (k < n) rd_chk(OFS_IDATA, 32'(avg_exp(b0, q)));
    end
    complete_run;
  end
endmodule // test_video_field_reducer
